// >>> verilog/dpe_ctrl.sv
/*
 * Data paging and data EEPROM controller: program-memory window,
 * bank paging of 00h..3Fh, EEPROM control, byte and row writes.
 * Assumes the core gives one-cycle read/write strobes, synchronous
 * to sys_clk_i, and program memory answers combinationally.
 */
`timescale 1ns/100ps
`default_nettype none

module dpe_ctrl import dpe_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o,
	output logic             hit_o,
	output logic      [11:0] pmem_addr_o,
	input  wire logic [7:0]  pmem_data_i,
	input  wire logic        stop_i,
	input  wire logic [15:0] opt_bytes_i,
	output logic      [15:0] opt_o,
	output logic             nvm_busy_flag_o,
	output logic             nvm_standby_o,
	output logic             row_err_o
);
	// ************************************************************
	// declarations
	// ************************************************************
	logic [WIN_BITS-1:0] data_window_select_q;
	logic [4:0]          bank_select_q;
	logic                nvm_standby_q;
	logic                program_enable_q;
	logic                row_mode_enable_q;
	logic                row_program_start_q;
	logic [CNT_W-1:0]    cnt_q;
	logic                cyc_row_q;
	logic                row_lock_q;
	logic [ROW_IW-1:0]   row_q;
	logic                row_page_q;
	logic [PAGE_AW:0]    pend_addr_q;
	logic [7:0]          pend_data_q;
	logic [7:0]          rdata_q;
	logic                hit_q;
	logic                row_err_q;
	logic [15:0]         opt_q;

	logic busy, nvm_sel, nvm_ok, bank_acc, ctl_wr;
	logic nvm_wr, byte_start, row_match, row_wr, row_bad;
	logic start_ok, prog_end, row_arm, row_clear;
	logic ram_sel, commit_row, commit_byte, nvm_we;
	logic [CNT_W-1:0]   row_left;
	logic [ROW_IW-1:0]  row_idx;
	logic [PAGE_AW:0]   nvm_waddr;
	logic [7:0]         nvm_wdata, nvm_rdata, ram_rdata, row_rdata;
	logic [ROW_BYTES-1:0] row_mask;

	// ************************************************************
	// decode
	// ************************************************************
	assign busy     = (cnt_q != '0);
	assign ram_sel  = bank_select_q[BANK_RAM2_BIT];
	assign nvm_sel  = bank_select_q[BANK_NVM0_BIT]
	                | bank_select_q[BANK_NVM1_BIT];
	assign nvm_ok   = nvm_sel && !nvm_standby_q && !busy;
	assign bank_acc = (addr_i[7:6] == REGION_BANK);
	assign ctl_wr   = wr_i && (addr_i == ADDR_NVM_CTL) && !busy;

	// an EEPROM write only counts with programming enabled
	assign nvm_wr     = wr_i && bank_acc && nvm_ok
	                  && program_enable_q;
	assign byte_start = nvm_wr && !row_mode_enable_q;
	assign row_match  = ({bank_select_q[BANK_NVM1_BIT],
	                      addr_i[5:3]} == {row_page_q, row_q});
	assign row_wr  = nvm_wr && row_mode_enable_q
	               && (!row_lock_q || row_match);
	assign row_bad = nvm_wr && row_mode_enable_q
	               && row_lock_q && !row_match;

	// start needs enable and row mode set in the same write, row mode already armed
	assign start_ok = ctl_wr && wdata_i[CTL_START_BIT]
	                && wdata_i[CTL_PROGEN_BIT]
	                && wdata_i[CTL_ROWMODE_BIT]
	                && row_mode_enable_q;
	assign prog_end = (cnt_q == CNT_W'(1));

	// latches clear on arming; dropped on disarm or cycle end
	assign row_arm   = ctl_wr && wdata_i[CTL_ROWMODE_BIT]
	                 && !row_mode_enable_q;
	assign row_clear = row_arm || prog_end
	                 || (ctl_wr && !wdata_i[CTL_ROWMODE_BIT]);

	// ************************************************************
	// paging registers
	// ************************************************************
	// no reset here: contents are undefined until software writes
	always_ff @(posedge sys_clk_i) begin
		if (wr_i && addr_i == ADDR_WINDOW_SEL) begin
			data_window_select_q <= wdata_i[WIN_BITS-1:0];
		end
	end

	// survives reset; nothing but a write touches it
	always_ff @(posedge sys_clk_i) begin
		if (wr_i && addr_i == ADDR_BANK_SEL) begin
			bank_select_q <= wdata_i[4:0];
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	// write-only bits; reserved bits 7:4 beside standby dropped
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			nvm_standby_q       <= CTL_RESET[CTL_STANDBY_BIT];
			program_enable_q    <= CTL_RESET[CTL_PROGEN_BIT];
			row_mode_enable_q   <= CTL_RESET[CTL_ROWMODE_BIT];
			row_program_start_q <= CTL_RESET[CTL_START_BIT];
		end else begin
			if (ctl_wr) begin
				nvm_standby_q     <= wdata_i[CTL_STANDBY_BIT];
				program_enable_q  <= wdata_i[CTL_PROGEN_BIT];
				row_mode_enable_q <= wdata_i[CTL_ROWMODE_BIT];
				if (start_ok) begin
					row_program_start_q <= 1'b1;
				end
			end
			if (prog_end) begin
				row_mode_enable_q   <= 1'b0;
				row_program_start_q <= 1'b0;
			end
			// STOP wins over a same-cycle control write
			if (stop_i) begin
				nvm_standby_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// programming cycle
	// ************************************************************
	// one counter times both byte and row cycles
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cnt_q     <= '0;
			cyc_row_q <= 1'b0;
		end else if (byte_start || start_ok) begin
			cnt_q     <= CNT_W'(PROG_CYCLES);
			cyc_row_q <= start_ok;
		end else if (busy) begin
			cnt_q <= cnt_q - CNT_W'(1);
		end
	end

	// byte mode goes straight to its target, no staging array
	always_ff @(posedge sys_clk_i) begin
		if (byte_start) begin
			pend_addr_q <= {bank_select_q[BANK_NVM1_BIT],
			                addr_i[PAGE_AW-1:0]};
			pend_data_q <= wdata_i;
		end
	end

	// first row write locks the row until disarm or cycle end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || row_clear) begin
			row_lock_q <= 1'b0;
		end else if (row_wr && !row_lock_q) begin
			row_lock_q <= 1'b1;
			row_q      <= addr_i[5:3];
			row_page_q <= bank_select_q[BANK_NVM1_BIT];
		end
	end

	// writes to a foreign row are flagged and dropped
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			row_err_q <= 1'b0;
		end else begin
			row_err_q <= row_bad;
		end
	end

	dpe_row #(
		.N  (ROW_BYTES),
		.IW (ROW_IW)
	) u_row (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.clear_i   (row_clear),
		.we_i      (row_wr),
		.widx_i    (addr_i[ROW_IW-1:0]),
		.wdata_i   (wdata_i),
		.ridx_i    (row_idx),
		.rdata_o   (row_rdata),
		.mask_o    (row_mask)
	);

	// row bytes go out one a cycle in the last eight busy cycles;
	// needs PROG_CYCLES of at least eight
	assign row_left    = CNT_W'(ROW_BYTES) - cnt_q;
	assign row_idx     = row_left[ROW_IW-1:0];
	assign commit_row  = busy && cyc_row_q
	                   && (cnt_q <= CNT_W'(ROW_BYTES))
	                   && row_mask[row_idx];
	assign commit_byte = prog_end && !cyc_row_q;
	assign nvm_we      = commit_row || commit_byte;
	assign nvm_waddr   = commit_row ? {row_page_q, row_q, row_idx}
	                                : pend_addr_q;
	assign nvm_wdata   = commit_row ? row_rdata : pend_data_q;

	// ************************************************************
	// storage
	// ************************************************************
	dpe_mem #(
		.AW (PAGE_AW + 1)
	) u_nvm (
		.sys_clk_i (sys_clk_i),
		.we_i      (nvm_we),
		.waddr_i   (nvm_waddr),
		.wdata_i   (nvm_wdata),
		.raddr_i   ({bank_select_q[BANK_NVM1_BIT],
		               addr_i[PAGE_AW-1:0]}),
		.rdata_o   (nvm_rdata)
	);

	dpe_mem #(
		.AW (PAGE_AW)
	) u_ram2 (
		.sys_clk_i (sys_clk_i),
		.we_i      (wr_i && bank_acc && ram_sel),
		.waddr_i   (addr_i[PAGE_AW-1:0]),
		.wdata_i   (wdata_i),
		.raddr_i   (addr_i[PAGE_AW-1:0]),
		.rdata_o   (ram_rdata)
	);

	// ************************************************************
	// read path
	// ************************************************************
	assign pmem_addr_o = {data_window_select_q,
	                      addr_i[WIN_BITS-1:0]};

	// answer one cycle after the strobe; write-only reads give 0
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_q <= 8'h00;
			hit_q   <= 1'b0;
		end else if (rd_i) begin
			hit_q   <= 1'b1;
			rdata_q <= 8'h00;
			if (bank_acc) begin
				if (ram_sel) begin
					rdata_q <= ram_rdata;
				end else if (nvm_ok) begin
					rdata_q <= nvm_rdata;
				end
			end else if (addr_i[7:6] == REGION_WINDOW) begin
				rdata_q <= pmem_data_i;
			end else if (addr_i == ADDR_NVM_CTL) begin
				rdata_q[CTL_BUSY_BIT] <= busy;
			end else begin
				hit_q <= 1'b0;
			end
		end else begin
			hit_q <= 1'b0;
		end
	end

	// ************************************************************
	// option bytes
	// ************************************************************
	// sampled every cycle reset is held; frozen after release
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			opt_q <= opt_bytes_i;
		end
	end

	assign rdata_o         = rdata_q;
	assign hit_o           = hit_q;
	assign opt_o           = opt_q;
	assign nvm_busy_flag_o = busy;
	assign nvm_standby_o   = nvm_standby_q;
	assign row_err_o       = row_err_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	sequence s_row_arm;
		ctl_wr && wdata_i[CTL_ROWMODE_BIT] && !row_mode_enable_q;
	endsequence

	sequence s_prog_start;
		byte_start || start_ok;
	endsequence

	AST_CYCLE_LEN: assert property (
		s_prog_start |=> busy && cnt_q == CNT_W'(PROG_CYCLES))
		else $error("programming cycle length wrong");

	// the cycle's own end may clear start, so that edge is left out
	AST_CTL_FROZEN: assert property (
		busy && !prog_end && wr_i && addr_i == ADDR_NVM_CTL |=>
		$stable(program_enable_q) && $stable(row_program_start_q))
		else $error("control changed while busy");

	AST_NO_ENABLE: assert property (
		wr_i && bank_acc && !program_enable_q && !busy |=> !busy)
		else $error("write without enable started a cycle");

	AST_START_GATE: assert property (
		ctl_wr && wdata_i[CTL_START_BIT] && !row_program_start_q
		&& !(wdata_i[CTL_PROGEN_BIT] && row_mode_enable_q)
		|=> !row_program_start_q && !busy)
		else $error("row start taken without both enables");

	AST_AUTO_CLEAR: assert property (
		prog_end |=> !row_mode_enable_q && !row_program_start_q
		&& !busy)
		else $error("row mode not cleared at cycle end");

	AST_STOP_OFF: assert property (
		stop_i |=> nvm_standby_q)
		else $error("stop did not put eeprom in standby");

	AST_WINDOW: assert property (
		rd_i && addr_i[7:6] == REGION_WINDOW |->
		pmem_addr_o[5:0] == addr_i[5:0]
		##1 hit_o && rdata_o == $past(pmem_data_i))
		else $error("window read mismatch");

	AST_ABORT: assert property (
		rd_i && bank_acc && !ram_sel && (busy || nvm_standby_q)
		|=> hit_o && rdata_o == 8'h00)
		else $error("eeprom read not aborted");

	AST_ROW_CLEAR: assert property (
		s_row_arm |=> row_mask == '0 && !row_lock_q)
		else $error("row latches not cleared on arming");

	AST_FOREIGN_ROW: assert property (
		row_bad |=> row_err_o && $stable(row_mask))
		else $error("foreign row write not flagged");
endmodule

`default_nettype wire

// >>> verilog/dpe_pkg.sv
/*
 * Package of the data paging and data EEPROM controller: register
 * addresses, field positions, reset values and timing counts.
 * Assumes an 8-bit data space driven by the processor core.
 */
`default_nettype none

package dpe_pkg;

	// ************************************************************
	// register addresses in data space
	// ************************************************************
	localparam logic [7:0] ADDR_WINDOW_SEL = 8'hC9;
	localparam logic [7:0] ADDR_BANK_SEL   = 8'hE8;
	localparam logic [7:0] ADDR_NVM_CTL    = 8'hEA;

	// address regions, by bits 7:6 of the data address
	localparam logic [1:0] REGION_BANK   = 2'h0; // 00h..3Fh
	localparam logic [1:0] REGION_WINDOW = 2'h1; // 40h..7Fh

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int WIN_BITS        = 6;
	localparam int BANK_RAM2_BIT   = 4;
	localparam int BANK_NVM1_BIT   = 1;
	localparam int BANK_NVM0_BIT   = 0;
	localparam int CTL_STANDBY_BIT = 6;
	localparam int CTL_START_BIT   = 3;
	localparam int CTL_ROWMODE_BIT = 2;
	localparam int CTL_BUSY_BIT    = 1;
	localparam int CTL_PROGEN_BIT  = 0;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// ************************************************************
	// geometry and timing
	// ************************************************************
	localparam int PAGE_AW      = 6;  // 64-byte pages
	localparam int ROW_BYTES    = 8;
	localparam int ROW_IW       = 3;  // byte index in a row
	localparam int CNT_W        = 24;
	localparam int CLK_MHZ      = 125;
	localparam int PROG_TIME_US = 5000;
	localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;

endpackage

`default_nettype wire

// >>> verilog/dpe_mem.sv
/*
 * Byte-wide flip-flop storage, one write port and one
 * combinational read port. Assumes a single clock.
 */
`timescale 1ns/100ps
`default_nettype none

module dpe_mem #(
	parameter int AW = 6
) (
	input  wire logic          sys_clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [7:0]    rdata_o
);
	logic [7:0] mem_q [2**AW];

	// cell contents are not reset, as a real array
	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = mem_q[raddr_i];
endmodule

`default_nettype wire

// >>> verilog/dpe_row.sv
/*
 * Volatile row latches for row programming: data bytes plus a
 * mask of the bytes written since the last clear.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module dpe_row #(
	parameter int N  = 8,
	parameter int IW = 3
) (
	input  wire logic          sys_clk_i,
	input  wire logic          srst_i,
	input  wire logic          clear_i,
	input  wire logic          we_i,
	input  wire logic [IW-1:0] widx_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic [IW-1:0] ridx_i,
	output logic      [7:0]    rdata_o,
	output logic      [N-1:0]  mask_o
);
	logic [7:0]   data_q [N];
	logic [N-1:0] mask_q;

	// mask tracks which latches hold fresh data
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || clear_i) begin
			mask_q <= '0;
		end else if (we_i) begin
			mask_q[widx_i] <= 1'b1;
		end
	end

	// data itself needs no reset, the mask guards it
	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			data_q[widx_i] <= wdata_i;
		end
	end

	assign rdata_o = data_q[ridx_i];
	assign mask_o  = mask_q;
endmodule

`default_nettype wire

// >>> verification/dpe_core_model.sv
/*
 * Processor core model: byte reads and writes in data space, plus a
 * combinational program memory behind the window.
 * Assumes one clock; answers arrive one cycle after the read strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module dpe_core_model (
	input  wire logic        sys_clk_i,
	input  wire logic [11:0] pmem_addr_i,
	input  wire logic [7:0]  rdata_i,
	input  wire logic        hit_i,
	output logic      [7:0]  pmem_data_o,
	output logic      [7:0]  addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [7:0]  wdata_o
);
	// ************************************************************
	// program memory: pattern depends on all twelve address bits
	// ************************************************************
	assign pmem_data_o = pmem_addr_i[7:0] ^ {pmem_addr_i[11:8], 4'h5};

	initial begin
		addr_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end

	// one write; bus shows inverted values once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	// one read; answer taken one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] q,
		output logic h);
		@(posedge sys_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1;
		q = rdata_i;
		h = hit_i;
	endtask
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
/*
 * Self-checking bench of the paging and EEPROM controller.
 * Assumes the core model drives the data bus, 8 ns clock.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import dpe_pkg::*;
	localparam int PC = 20; // short programming cycle keeps run brief

	logic        sys_clk_i;
	logic        srst_i;
	logic        stop_i;
	logic [7:0]  addr, wdata, rdata_o, pmem_data;
	logic        rd, wr, hit_o, busy, standby, row_err_o, err_seen;
	logic [11:0] pmem_addr_o;
	logic [15:0] opt_o;
	logic [15:0] opt_bytes = 16'hA55A;
	logic [7:0]  q;
	logic        h;
	int          n_mismatch = 0;
	int          n_checks = 0;

	// ************************************************************
	// clock, design, core model
	// ************************************************************
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	dpe_ctrl #(.PROG_CYCLES(PC)) DUT (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr),
		.rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata_o),
		.hit_o(hit_o), .pmem_addr_o(pmem_addr_o),
		.pmem_data_i(pmem_data), .stop_i(stop_i),
		.opt_bytes_i(opt_bytes), .opt_o(opt_o),
		.nvm_busy_flag_o(busy), .nvm_standby_o(standby),
		.row_err_o(row_err_o));

	dpe_core_model CORE (
		.sys_clk_i(sys_clk_i), .pmem_addr_i(pmem_addr_o),
		.rdata_i(rdata_o), .hit_i(hit_o), .pmem_data_o(pmem_data),
		.addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

	// sticky capture, the error pulse lasts one cycle only
	always @(posedge sys_clk_i) begin
		if (srst_i)
			err_seen <= 1'b0;
		else if (row_err_o === 1'b1)
			err_seen <= 1'b1;
	end

	// ************************************************************
	// checks and ending
	// ************************************************************
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		CORE.rd(a, q, h);
		chk("read hit", 16'h0001, {15'h0, h});
		chk("read data", {8'h00, e}, {8'h00, q});
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// counts busy cycles; bounded in case busy sticks
	task automatic wait_idle(output int n);
		n = 0;
		#1;
		while (busy === 1'b1 && n < 200) begin
			n++;
			@(posedge sys_clk_i);
			#1;
		end
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		chk("opt", opt_bytes, opt_o);
		chk("busy", 16'h0, {15'h0, busy});
		chk("standby", 16'h0, {15'h0, standby});
		rchk(ADDR_NVM_CTL, CTL_RESET);
		$display("reset test done");
	endtask

	task automatic t_window;
		// window 2Ah puts 40h at program address A80h
		CORE.wr(ADDR_WINDOW_SEL, 8'hEA);
		rchk(8'h45, 8'h85 ^ 8'hA5);
		rchk(8'h7F, 8'hBF ^ 8'hA5);
		CORE.rd(ADDR_WINDOW_SEL, q, h);
		chk("window read hit", 16'h0, {15'h0, h});
		$display("window test done");
	endtask

	task automatic t_ram_page;
		CORE.wr(ADDR_BANK_SEL, 8'h10);
		CORE.wr(8'h07, 8'h55);
		rchk(8'h07, 8'h55);
		CORE.rd(ADDR_BANK_SEL, q, h);
		chk("bank read hit", 16'h0, {15'h0, h});
		$display("ram page test done");
	endtask

	task automatic t_byte;
		int n;
		CORE.wr(ADDR_BANK_SEL, 8'h01);
		CORE.wr(8'h19, 8'hFF);
		#1 chk("busy no enable", 16'h0, {15'h0, busy});
		CORE.wr(ADDR_NVM_CTL, 8'h01);
		CORE.wr(8'h19, 8'h3C);
		wait_idle(n);
		chk("busy cycles", PC[15:0], n[15:0]);
		rchk(8'h19, 8'h3C);
		$display("byte program test done");
	endtask

	task automatic t_row;
		int n;
		// start without row mode armed must not begin a cycle
		CORE.wr(ADDR_NVM_CTL, 8'h09);
		#1 chk("start gate", 16'h0, {15'h0, busy});
		CORE.wr(ADDR_NVM_CTL, 8'h05);
		CORE.wr(8'h18, 8'h11);
		CORE.wr(8'h1A, 8'h22);
		CORE.wr(8'h20, 8'h33);
		#9 chk("row error", 16'h1, {15'h0, err_seen});
		CORE.wr(ADDR_NVM_CTL, 8'h0D);
		rchk(ADDR_NVM_CTL, 8'h02);
		rchk(8'h18, 8'h00);
		CORE.wr(ADDR_NVM_CTL, 8'h00);
		wait_idle(n);
		rchk(8'h18, 8'h11);
		rchk(8'h1A, 8'h22);
		rchk(8'h19, 8'h3C);
		rchk(ADDR_NVM_CTL, 8'h00);
		// enable kept through the ignored write, row mode gone
		CORE.wr(8'h1B, 8'h44);
		wait_idle(n);
		chk("byte after row", PC[15:0], n[15:0]);
		rchk(8'h1B, 8'h44);
		$display("row program test done");
	endtask

	task automatic t_standby;
		CORE.wr(ADDR_NVM_CTL, 8'h40);
		#1 chk("standby set", 16'h1, {15'h0, standby});
		rchk(8'h18, 8'h00);
		CORE.wr(ADDR_NVM_CTL, 8'h00);
		#1 chk("standby clear", 16'h0, {15'h0, standby});
		@(posedge sys_clk_i);
		stop_i <= 1'b1;
		@(posedge sys_clk_i);
		stop_i <= 1'b0;
		#1 chk("stop standby", 16'h1, {15'h0, standby});
		$display("standby test done");
	endtask

	// mid-run reset: new option bytes, paging registers kept
	task automatic t_rereset;
		@(posedge sys_clk_i);
		opt_bytes <= 16'h3CC3;
		srst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		#1 chk("opt reload", 16'h3CC3, opt_o);
		chk("standby reset", 16'h0, {15'h0, standby});
		rchk(8'h18, 8'h11);
		rchk(8'h5F, 8'h9F ^ 8'hA5);
		$display("reset rerun test done");
	endtask

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		srst_i = 1'b1;
		stop_i = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		#1;
		t_reset();
		t_window();
		t_ram_page();
		t_byte();
		t_row();
		t_standby();
		t_rereset();
		conclude();
	end

	// run needs about 140 cycles; this leaves wide margin
	initial begin
		#40000;
		n_mismatch++;
		conclude();
	end
endmodule

`default_nettype wire
